/* hdl/gamma_word_writer.sv */
// two-wire slave with channel registers and nonvolatile program sequencing
//
// Summary of operation
// - each channel value is one sixteen-bit word
// - read-back upper six bits are always zero
// - bit 14 selects register-only or program write
// - upper byte first, carries value bits nine, eight
// - value is an unsigned code 0 to 1023
// - latch word at eighth falling clock, lower byte
// - guard low discards channel and store writes
// - acknowledge transfers whatever the guard level
// - programming of flagged channels starts at STOP
// - program done within 35ms single, 420ms all
// - every command refused with nack while programming
// - register-only writes accepted back to back
// - outputs stay enabled during programming
// - bus address 1110100 or 1110101 by select
// - pointer 0 control, 1 to 15 channels
// - read at pointer zero gives two nulls first
`timescale 1ns/1ns
`default_nettype none
module gamma_word_writer #(
	parameter int unsigned PROG_CH_CYCLES = gamma_nv_pkg::PROG_CH_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic write_guard_n,
	input wire logic address_select_input,
	output logic [gamma_nv_pkg::GAMMA_CH*gamma_nv_pkg::CODE_W-1:0] gamma_outputs,
	output logic [gamma_nv_pkg::CODE_W-1:0] common_voltage_output,
	output logic outputs_enabled,
	output logic nvm_busy,
	output logic nvm_wr_en,
	output logic [gamma_nv_pkg::CH_IDX_W-1:0] nvm_wr_index,
	output logic [gamma_nv_pkg::CODE_W-1:0] nvm_wr_data
);
	import gamma_nv_pkg::*;

	function automatic logic ptr_is_channel(input logic [PTR_W-1:0] p);
		ptr_is_channel = (p != PTR_CONTROL) && (p <= PTR_LAST_CH);
	endfunction

	function automatic logic [CH_IDX_W-1:0] lowest_set(input logic [NUM_CH-1:0] v);
		logic [CH_IDX_W-1:0] r;
		r = '0;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			if (v[i])
				r = CH_IDX_W'(i);
		end
		lowest_set = r;
	endfunction

	// start and stop are only visible as sda edges while scl is high
	logic start_tog_r;
	logic stop_tog_r;
	always_ff @(negedge sda_in)
	begin
		if (!reset_n)
			start_tog_r <= 1'b0;
		else if (scl)
			start_tog_r <= ~start_tog_r;
	end
	always_ff @(posedge sda_in)
	begin
		if (!reset_n)
			stop_tog_r <= 1'b0;
		else if (scl)
			stop_tog_r <= ~stop_tog_r;
	end

	// link side, sampled on rising scl
	logic busy_r;
	logic [2:0] lk_pins_s;
	logic start_s;
	logic start_seen_r;
	link_state_e state_r, state_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [BYTE_W-1:0] shreg_r;
	logic [BYTE_W-1:0] hi_byte_r, hi_byte_nxt;
	logic [PTR_W-1:0] idx_r, idx_nxt;
	logic half_lo_r, half_lo_nxt;
	logic [CODE_W:0] file_r [NUM_CH];
	logic [NUM_CH-1:0] upd_tog_r;
	logic sda_oe_r;

	bit_sync #(.W(3)) link_pin_sync (
		.clk(scl),
		.reset_n(reset_n),
		.d({busy_r, write_guard_n, address_select_input}),
		.q(lk_pins_s)
	);
	bit_sync #(.W(1)) link_start_sync (
		.clk(scl),
		.reset_n(reset_n),
		.d(start_tog_r),
		.q(start_s)
	);

	wire busy_s = lk_pins_s[2];
	wire guard_open_s = lk_pins_s[1];
	wire [6:0] own_addr = lk_pins_s[0] ? DEV_ADDR_SEL_HIGH : DEV_ADDR_SEL_LOW;
	wire new_start = start_s ^ start_seen_r;
	wire [BYTE_W-1:0] byte_now = {shreg_r[BYTE_W-2:0], sda_in};
	wire byte_done = (cnt_r == BIT_LAST);
	wire [PTR_W-1:0] idx_step = (idx_r < PTR_PAST_END) ? idx_r + 5'h01 : idx_r;
	wire [CH_IDX_W-1:0] ch_slot = idx_r[CH_IDX_W-1:0] - 4'h1;
	// pointer zero and past-end slots read as null words
	wire [CODE_W:0] rd_word = ptr_is_channel(idx_r) ? file_r[ch_slot] : '0;
	wire [BYTE_W-1:0] tx_byte = half_lo_r ? rd_word[BYTE_W-1:0]
		: {{(BYTE_W - UPPER_CODE_W){1'b0}}, rd_word[CODE_W-1:BYTE_W]};
	wire tx_bit = tx_byte[BIT_LAST - cnt_r];

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		hi_byte_nxt = hi_byte_r;
		idx_nxt = idx_r;
		half_lo_nxt = half_lo_r;
		if (new_start)
		begin
			// the start reached us three edges late; those three bits are already shifted in
			state_nxt = L_ADDR;
			cnt_nxt = START_LAG_BITS;
		end
		else
		begin
			unique case (state_r)
				L_IDLE:
				begin
					cnt_nxt = '0;
				end
				L_ADDR:
				begin
					cnt_nxt = cnt_r + 3'h1;
					if (byte_done)
						state_nxt = (byte_now[BYTE_W-1:1] == own_addr && !busy_s) ? L_ADDR_ACK : L_IDLE;
				end
				L_ADDR_ACK:
				begin
					cnt_nxt = '0;
					state_nxt = shreg_r[0] ? L_RD_DATA : L_PTR;
				end
				L_PTR:
				begin
					cnt_nxt = cnt_r + 3'h1;
					if (byte_done)
					begin
						state_nxt = L_PTR_ACK;
						idx_nxt = (byte_now > BYTE_W'(PTR_LAST_CH)) ? PTR_PAST_END : byte_now[PTR_W-1:0];
						half_lo_nxt = 1'b0;
					end
				end
				L_PTR_ACK:
				begin
					cnt_nxt = '0;
					state_nxt = L_WR_DATA;
				end
				L_WR_DATA:
				begin
					cnt_nxt = cnt_r + 3'h1;
					if (byte_done)
					begin
						state_nxt = L_WR_ACK;
						if (!half_lo_r)
							hi_byte_nxt = byte_now;
					end
				end
				L_WR_ACK:
				begin
					cnt_nxt = '0;
					state_nxt = L_WR_DATA;
					half_lo_nxt = ~half_lo_r;
					if (half_lo_r)
						idx_nxt = idx_step;
				end
				L_RD_DATA:
				begin
					cnt_nxt = cnt_r + 3'h1;
					if (byte_done)
						state_nxt = L_RD_ACK;
				end
				L_RD_ACK:
				begin
					cnt_nxt = '0;
					state_nxt = sda_in ? L_IDLE : L_RD_DATA;
					half_lo_nxt = ~half_lo_r;
					if (half_lo_r)
						idx_nxt = idx_step;
				end
			endcase
		end
	end

	always_ff @(posedge scl)
	begin
		if (!reset_n)
		begin
			state_r <= L_IDLE;
			cnt_r <= '0;
			shreg_r <= '0;
			hi_byte_r <= '0;
			idx_r <= PTR_CONTROL;
			half_lo_r <= 1'b0;
			start_seen_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shreg_r <= byte_now;
			hi_byte_r <= hi_byte_nxt;
			idx_r <= idx_nxt;
			half_lo_r <= half_lo_nxt;
			start_seen_r <= start_s;
		end
	end

	// link side, driven on falling scl
	wire in_ack = (state_r == L_ADDR_ACK) || (state_r == L_PTR_ACK) || (state_r == L_WR_ACK);
	wire drive_low = in_ack || (state_r == L_RD_DATA && !tx_bit);
	// guard low still acks but never touches the file, so nothing gets flagged for programming
	wire word_hit = (state_r == L_WR_ACK) && half_lo_r && guard_open_s && ptr_is_channel(idx_r);

	always_ff @(negedge scl)
	begin
		if (!reset_n)
		begin
			sda_oe_r <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			sda_oe_r <= drive_low;
			sda_out <= 1'b0;
		end
	end
	assign sda_oe = sda_oe_r;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_file
			wire this_hit = word_hit && (ch_slot == CH_IDX_W'(g));
			always_ff @(negedge scl)
			begin
				if (!reset_n)
				begin
					file_r[g] <= '0;
					upd_tog_r[g] <= 1'b0;
				end
				else if (this_hit)
				begin
					file_r[g] <= {hi_byte_r[PROG_BIT_IN_UPPER], hi_byte_r[UPPER_CODE_W-1:0], shreg_r};
					upd_tog_r[g] <= ~upd_tog_r[g];
				end
			end
		end
	endgenerate

	// core side on mclk; file words are steady long before their toggle arrives
	logic [NUM_CH-1:0] upd_s;
	logic [NUM_CH-1:0] upd_prev_r;
	logic stop_s;
	logic stop_q_r;
	logic stop_prev_r;
	logic [CODE_W-1:0] code_r [NUM_CH];
	logic [NUM_CH-1:0] pend_r, pend_nxt;
	logic [NUM_CH-1:0] set_mask;
	logic [NUM_CH-1:0] clr_mask;
	prog_state_e prog_r, prog_nxt;
	logic [PROG_CNT_W-1:0] pcnt_r, pcnt_nxt;
	logic [CH_IDX_W-1:0] cur_r, cur_nxt;
	logic launch;

	bit_sync #(.W(NUM_CH)) core_upd_sync (
		.clk(mclk),
		.reset_n(reset_n),
		.d(upd_tog_r),
		.q(upd_s)
	);
	bit_sync #(.W(1)) core_stop_sync (
		.clk(mclk),
		.reset_n(reset_n),
		.d(stop_tog_r),
		.q(stop_s)
	);

	wire [NUM_CH-1:0] upd_evt = upd_s ^ upd_prev_r;
	// stop is held back one more cycle so the last word's flag is already pending
	wire stop_evt = stop_q_r ^ stop_prev_r;
	wire [NUM_CH-1:0] rest = pend_r & ~clr_mask;
	wire [CH_IDX_W-1:0] next_ch = lowest_set(rest);
	wire [PROG_CNT_W-1:0] slot_last = PROG_CNT_W'(PROG_CH_CYCLES - 1);
	// slot-end clear kept out of the sequencer so no loop forms through rest
	wire slot_end = (prog_r == P_RUN) && (pcnt_r == '0);
	assign clr_mask = slot_end ? (NUM_CH'(1) << cur_r) : '0;

	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_core
			assign set_mask[g] = upd_evt[g] && file_r[g][CODE_W];
			always_ff @(posedge mclk)
			begin
				if (!reset_n)
					code_r[g] <= '0;
				else if (upd_evt[g])
					code_r[g] <= file_r[g][CODE_W-1:0];
			end
		end
		for (g = 0; g < GAMMA_CH; g++)
		begin : g_out
			assign gamma_outputs[g*CODE_W +: CODE_W] = code_r[g];
		end
	endgenerate
	assign common_voltage_output = code_r[NUM_CH-1];

	always_comb
	begin
		prog_nxt = prog_r;
		pcnt_nxt = pcnt_r;
		cur_nxt = cur_r;
		launch = 1'b0;
		unique case (prog_r)
			P_IDLE:
			begin
				if (stop_evt && (|pend_r))
				begin
					prog_nxt = P_RUN;
					launch = 1'b1;
				end
			end
			P_RUN:
			begin
				if (pcnt_r == '0)
				begin
					if (|rest)
						launch = 1'b1;
					else
						prog_nxt = P_IDLE;
				end
				else
					pcnt_nxt = pcnt_r - 20'h00001;
			end
		endcase
		if (launch)
		begin
			cur_nxt = next_ch;
			pcnt_nxt = slot_last;
		end
	end

	// a new flag wins over the clear of a finished slot
	assign pend_nxt = rest | set_mask;

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			upd_prev_r <= '0;
			stop_q_r <= 1'b0;
			stop_prev_r <= 1'b0;
			pend_r <= '0;
			prog_r <= P_IDLE;
			pcnt_r <= '0;
			cur_r <= '0;
		end
		else
		begin
			upd_prev_r <= upd_s;
			stop_q_r <= stop_s;
			stop_prev_r <= stop_q_r;
			pend_r <= pend_nxt;
			prog_r <= prog_nxt;
			pcnt_r <= pcnt_nxt;
			cur_r <= cur_nxt;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			busy_r <= 1'b0;
			nvm_wr_en <= 1'b0;
			nvm_wr_index <= '0;
			nvm_wr_data <= '0;
			outputs_enabled <= 1'b0;
		end
		else
		begin
			busy_r <= (prog_nxt == P_RUN);
			nvm_wr_en <= launch;
			if (launch)
			begin
				nvm_wr_index <= next_ch + 4'h1;
				nvm_wr_data <= code_r[next_ch];
			end
			// outputs never float for programming; only reset gates them
			outputs_enabled <= 1'b1;
		end
	end
	assign nvm_busy = busy_r;
endmodule
`default_nettype wire

/* hdl/gamma_nv_pkg.sv */
// constants and state codes for the gamma word writer
package gamma_nv_pkg;
	localparam int NUM_CH = 15;
	localparam int GAMMA_CH = 14;
	localparam int CODE_W = 10;
	localparam int BYTE_W = 8;
	localparam int PROG_BIT = 14;
	localparam int PROG_BIT_IN_UPPER = PROG_BIT - BYTE_W;
	localparam int UPPER_CODE_W = CODE_W - BYTE_W;
	localparam int CH_IDX_W = 4;
	localparam int PTR_W = 5;
	localparam logic [6:0] DEV_ADDR_SEL_LOW = 7'h74;
	localparam logic [6:0] DEV_ADDR_SEL_HIGH = 7'h75;
	localparam logic [PTR_W-1:0] PTR_CONTROL = 5'h00;
	localparam logic [PTR_W-1:0] PTR_LAST_CH = 5'h0F;
	localparam logic [PTR_W-1:0] PTR_PAST_END = 5'h10;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] START_LAG_BITS = 3'h3;
	localparam int CLK_HZ = 10_000_000;
	localparam int PROG_ONE_MS = 35;
	localparam int PROG_ALL_MS = 420;
	// one slot per channel so a full program ends within the all-channel bound
	localparam int PROG_CH_CYCLES_DEF = (CLK_HZ / 1000) * PROG_ALL_MS / NUM_CH;
	localparam int PROG_CNT_W = 20;
	typedef enum logic [8:0] {
		L_IDLE = 9'h001,
		L_ADDR = 9'h002,
		L_ADDR_ACK = 9'h004,
		L_PTR = 9'h008,
		L_PTR_ACK = 9'h010,
		L_WR_DATA = 9'h020,
		L_WR_ACK = 9'h040,
		L_RD_DATA = 9'h080,
		L_RD_ACK = 9'h100
	} link_state_e;
	typedef enum logic [1:0] {
		P_IDLE = 2'h1,
		P_RUN = 2'h2
	} prog_state_e;
endpackage

/* hdl/bit_sync.sv */
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* tb/gamma_word_writer_chk.sv */
// concurrent checks on the gamma word writer ports
`timescale 1ns/1ns
`default_nettype none
module gamma_word_writer_chk #(
	parameter int unsigned PROG_CH_CYCLES = 20
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic write_guard_n,
	input wire logic address_select_input,
	input wire logic [gamma_nv_pkg::GAMMA_CH*gamma_nv_pkg::CODE_W-1:0] gamma_outputs,
	input wire logic [gamma_nv_pkg::CODE_W-1:0] common_voltage_output,
	input wire logic outputs_enabled,
	input wire logic nvm_busy,
	input wire logic nvm_wr_en,
	input wire logic [gamma_nv_pkg::CH_IDX_W-1:0] nvm_wr_index,
	input wire logic [gamma_nv_pkg::CODE_W-1:0] nvm_wr_data
);
	import gamma_nv_pkg::*;
	int busy_cnt_r;
	int guard_cnt_r;
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			busy_cnt_r <= 0;
			guard_cnt_r <= 0;
		end
		else
		begin
			busy_cnt_r <= nvm_busy ? busy_cnt_r + 1 : 0;
			guard_cnt_r <= write_guard_n ? 0 : (guard_cnt_r < 8 ? guard_cnt_r + 1 : 8);
		end
	end
	sequence prog_begin_s;
		$rose(nvm_busy);
	endsequence
	sequence one_pulse_s;
		nvm_wr_en ##1 !nvm_wr_en;
	endsequence
	enable_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) $past(reset_n) |-> outputs_enabled)
		else $error("outputs dropped");
	busy_refuse_a: assert property (@(posedge scl) disable iff (!reset_n) nvm_busy [*3] |-> !sda_oe)
		else $error("ack while programming");
	pulse_in_busy_a: assert property (@(posedge mclk) disable iff (!reset_n) nvm_wr_en |-> nvm_busy)
		else $error("store write outside programming");
	prog_begin_a: assert property (@(posedge mclk) disable iff (!reset_n) prog_begin_s |-> one_pulse_s)
		else $error("programming began without one pulse");
	busy_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
		busy_cnt_r <= NUM_CH * (PROG_CH_CYCLES + 2))
		else $error("programming too long");
	index_range_a: assert property (@(posedge mclk) disable iff (!reset_n) nvm_wr_en |-> nvm_wr_index != 4'h0)
		else $error("store write to control slot");
	guard_freeze_a: assert property (@(posedge mclk) disable iff (!reset_n) guard_cnt_r >= 6
		|-> $stable(gamma_outputs) && $stable(common_voltage_output) && !$rose(nvm_busy))
		else $error("write taken while guarded");
	drive_low_a: assert property (@(posedge mclk) disable iff (!reset_n) sda_out == 1'b0)
		else $error("data line driven high");
endmodule
bind gamma_word_writer gamma_word_writer_chk #(.PROG_CH_CYCLES(PROG_CH_CYCLES)) chk (.mclk(mclk), .reset_n(reset_n),
	.scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_guard_n(write_guard_n),
	.address_select_input(address_select_input), .gamma_outputs(gamma_outputs),
	.common_voltage_output(common_voltage_output), .outputs_enabled(outputs_enabled), .nvm_busy(nvm_busy),
	.nvm_wr_en(nvm_wr_en), .nvm_wr_index(nvm_wr_index), .nvm_wr_data(nvm_wr_data));
`default_nettype wire

/* tb/bus_ctl.sv */
// two-wire bus controller model, clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module bus_ctl (
	output logic scl,
	output logic sda_c,
	input wire logic sda_w
);
	initial
	begin
		scl = 1'b1;
		sda_c = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_c = b;
		#4 scl = 1'b1;
		#7 r = sda_w;
		scl = 1'b0;
		#4;
	endtask
	task automatic start();
		sda_c = 1'b1;
		#4 scl = 1'b1;
		#4 sda_c = 1'b0;
		#4 scl = 1'b0;
		#3;
	endtask
	task automatic stop();
		sda_c = 1'b0;
		#4 scl = 1'b1;
		#4 sda_c = 1'b1;
		#7;
	endtask
	// edges on both lines so the start and stop flops clear in reset
	task automatic wiggle();
		repeat (4)
		begin
			#8 scl = 1'b0;
			#8 sda_c = 1'b0;
			#8 scl = 1'b1;
			#8 sda_c = 1'b1;
		end
	endtask
	task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic nr);
		int i;
		logic r;
		for (i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(nine, nr);
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the gamma word writer
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import gamma_nv_pkg::*;
	localparam int PC = 20;
	logic mclk;
	logic reset_n;
	logic guard_n;
	logic asel;
	logic ack;
	logic [31:0] d;
	logic [6:0] own;
	logic [13:0] seen_q[$];
	int n;
	int bad_count;
	int cmp_count;
	wire scl;
	wire sda_c;
	wire sda_oe;
	wire oe;
	wire busy;
	wire wen;
	wire [3:0] widx;
	wire [9:0] wdat;
	wire [9:0] com;
	wire [139:0] gam;
	// open drain with pull-up: low if either party pulls
	wire sda = sda_c & ~sda_oe;
	bus_ctl ctl (.scl(scl), .sda_c(sda_c), .sda_w(sda));
	gamma_word_writer #(.PROG_CH_CYCLES(PC)) DUT (.mclk(mclk), .reset_n(reset_n), .scl(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .write_guard_n(guard_n), .address_select_input(asel), .gamma_outputs(gam),
		.common_voltage_output(com), .outputs_enabled(oe), .nvm_busy(busy), .nvm_wr_en(wen),
		.nvm_wr_index(widx), .nvm_wr_data(wdat));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [31:0] ws, output logic ok);
		logic [7:0] q;
		logic nr;
		int i;
		ctl.start();
		ctl.byte_io({a, 1'b0}, 1'b1, q, nr);
		ok = ~nr;
		if (ok)
		begin
			ctl.byte_io(p, 1'b1, q, nr);
			for (i = 3; i >= 0; i--)
				ctl.byte_io(ws[i*8 +: 8], 1'b1, q, nr);
		end
		ctl.stop();
		repeat (6) @(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] p, output logic [31:0] v);
		logic [7:0] q;
		logic nr;
		int i;
		ctl.start();
		ctl.byte_io({own, 1'b0}, 1'b1, q, nr);
		ctl.byte_io(p, 1'b1, q, nr);
		ctl.start();
		ctl.byte_io({own, 1'b1}, 1'b1, q, nr);
		for (i = 3; i >= 0; i--)
		begin
			ctl.byte_io(8'hFF, i == 0, q, nr);
			v[i*8 +: 8] = q;
		end
		ctl.stop();
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge mclk)
		if (wen === 1'b1)
			seen_q.push_back({widx, wdat});
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		bad_count++;
		end_of_test();
	end
	initial
	begin
		reset_n = 1'b0;
		guard_n = 1'b1;
		asel = 1'b0;
		own = DEV_ADDR_SEL_LOW;
		fork
			ctl.wiggle();
			repeat (5) @(negedge mclk);
		join
		reset_n = 1'b1;
		repeat (3) @(negedge mclk);
		check(oe, 1'b1);
		wr(own, 8'h01, 32'h83FF_0155, ack);
		check(ack, 1'b1);
		check(gam[19:0], {10'h155, 10'h3FF});
		rd(8'h01, d);
		check(d, 32'h03FF_0155);
		rd(8'h00, d);
		check(d, 32'h0000_03FF);
		wr(own, 8'h0F, 32'h0201_0123, ack);
		check(com, 10'h201);
		rd(8'h0F, d);
		check(d, 32'h0201_0000);
		@(negedge mclk);
		guard_n = 1'b0;
		wr(own, 8'h01, 32'h4123_4045, ack);
		check(ack, 1'b1);
		check(gam[19:0], {10'h155, 10'h3FF});
		check(busy, 1'b0);
		check(seen_q.size(), 0);
		guard_n = 1'b1;
		asel = 1'b1;
		repeat (2) @(negedge mclk);
		wr(own, 8'h03, 32'h0077_0000, ack);
		check(ack, 1'b0);
		own = DEV_ADDR_SEL_HIGH;
		wr(own, 8'h03, 32'h0077_0000, ack);
		check(gam[39:20], {10'h000, 10'h077});
		wr(own, 8'h0E, 32'h4011_4222, ack);
		check(ack, 1'b1);
		wr(own, 8'h01, 32'h0000_0000, ack);
		check(ack, 1'b0);
		check({oe, gam[139:130], com}, {1'b1, 10'h011, 10'h222});
		n = 0;
		while (busy !== 1'b0 && n < 3 * PC)
		begin
			@(negedge mclk);
			n++;
		end
		check(busy, 1'b0);
		check(seen_q.size(), 2);
		check({seen_q[0], seen_q[1]}, {4'hE, 10'h011, 4'hF, 10'h222});
		wr(own, 8'h01, 32'h0000_0000, ack);
		check(ack, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
